/* File: wdc_watchdog.sv */
`timescale 1ns/10ps
`default_nettype none

module wdc_watchdog (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_n,
	// Register port.
	input wire wdc_pkg::wdc_bus_req_t bus_req,
	output logic [15:0] rdata,
	// Pins from the power manager and slow oscillator.
	input wire logic osc_in,
	input wire logic hibernate_in,
	input wire logic shutdown_in,
	input wire logic active_in,
	// Timeout actions.
	output logic wdog_reset_req,
	output logic wdog_irq
);

	// Reset release synchroniser.
	logic [1:0] rst_sync_r;
	// Internal reset, released cleanly.
	logic rst_ni;

	// Two-stage pin synchronisers and the oscillator edge memory.
	logic [3:0] pin_meta_r;
	logic [3:0] pin_sync_r;
	logic osc_prev_r;
	// Slow oscillator rising edge, the timer side step.
	logic tick;
	logic hib_s;
	logic shut_s;
	logic act_s;

	// Bus side registers.
	wdc_pkg::wdc_ctrl_t ctrl_r;
	logic [15:0] load_r;
	logic lock_r;
	logic ctrl_pend_r;
	logic load_pend_r;
	logic kick_pend_r;
	logic [15:0] rdata_r;

	// Timer side copies and state.
	wdc_pkg::wdc_ctrl_t ctrl_t_r;
	logic [15:0] load_t_r;
	logic [15:0] count_r;
	logic [11:0] presc_r;
	logic [11:0] presc_top;
	logic pend_r;
	logic irq_r;
	logic reset_req_r;

	// Decoded accesses.
	logic wr_ctrl;
	logic wr_load;
	logic wr_kick;
	logic kick_good;
	logic kick_bad;
	// Timer enable gate and timeout events.
	logic run;
	logic count_to;
	logic timeout_ev;
	logic irq_mode;

	// The reset is applied at once and released over two edges.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_r <= 2'b00;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_ni = rst_sync_r[1];

	// Every pin passes two flops before any logic looks at it.
	always_ff @(posedge clock or negedge rst_ni) begin
		if (!rst_ni) begin
			pin_meta_r <= 4'h0;
			pin_sync_r <= 4'h0;
			osc_prev_r <= 1'b0;
		end else begin
			pin_meta_r <= {active_in, shutdown_in, hibernate_in, osc_in};
			pin_sync_r <= pin_meta_r;
			osc_prev_r <= pin_sync_r[wdc_pkg::PIN_OSC];
		end
	end

	// The counter advances only on slow oscillator edges.
	assign tick = pin_sync_r[wdc_pkg::PIN_OSC] & ~osc_prev_r;
	assign hib_s = pin_sync_r[wdc_pkg::PIN_HIB];
	assign shut_s = pin_sync_r[wdc_pkg::PIN_SHUT];
	assign act_s = pin_sync_r[wdc_pkg::PIN_ACT];

	// Configuration writes are dropped once locked.
	assign wr_ctrl = bus_req.wr && (bus_req.addr == wdc_pkg::OFS_CTRL) && !lock_r;
	assign wr_load = bus_req.wr && (bus_req.addr == wdc_pkg::OFS_LOAD) && !lock_r;
	assign wr_kick = bus_req.wr && (bus_req.addr == wdc_pkg::OFS_KICK);
	// Only the exact key counts as a service.
	assign kick_good = wr_kick && (bus_req.wdata == wdc_pkg::KICK_KEY);
	assign kick_bad = wr_kick && (bus_req.wdata != wdc_pkg::KICK_KEY);

	// Control register; bit 4 is stored as written by software.
	always_ff @(posedge clock or negedge rst_ni) begin
		if (!rst_ni) begin
			ctrl_r <= wdc_pkg::CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_r <= bus_req.wdata;
		end
	end

	// Load value register.
	always_ff @(posedge clock or negedge rst_ni) begin
		if (!rst_ni) begin
			load_r <= wdc_pkg::LOAD_RST;
		end else if (wr_load) begin
			load_r <= bus_req.wdata;
		end
	end

	// Lock sets on an enabling control write and only reset clears it.
	always_ff @(posedge clock or negedge rst_ni) begin
		if (!rst_ni) begin
			lock_r <= 1'b0;
		end else if (wr_ctrl && bus_req.wdata[5]) begin
			lock_r <= 1'b1;
		end
	end

	// Control pending: a new write wins over a clearing edge.
	always_ff @(posedge clock or negedge rst_ni) begin
		if (!rst_ni) begin
			ctrl_pend_r <= 1'b0;
		end else if (wr_ctrl) begin
			ctrl_pend_r <= 1'b1;
		end else if (tick) begin
			ctrl_pend_r <= 1'b0;
		end
	end

	// Load pending: same scheme as control.
	always_ff @(posedge clock or negedge rst_ni) begin
		if (!rst_ni) begin
			load_pend_r <= 1'b0;
		end else if (wr_load) begin
			load_pend_r <= 1'b1;
		end else if (tick) begin
			load_pend_r <= 1'b0;
		end
	end

	// Kick pending: cleared when the timer side performs the reload.
	always_ff @(posedge clock or negedge rst_ni) begin
		if (!rst_ni) begin
			kick_pend_r <= 1'b0;
		end else if (kick_good) begin
			kick_pend_r <= 1'b1;
		end else if (tick) begin
			kick_pend_r <= 1'b0;
		end
	end

	// Timer side takes the bus side values on each slow edge.
	always_ff @(posedge clock or negedge rst_ni) begin
		if (!rst_ni) begin
			ctrl_t_r <= wdc_pkg::CTRL_RST;
			load_t_r <= wdc_pkg::LOAD_RST;
		end else if (tick) begin
			ctrl_t_r <= ctrl_r;
			load_t_r <= load_r;
		end
	end

	// Prescaler terminal count for the selected divide.
	always_comb begin
		case (ctrl_t_r.pre)
			2'h0: presc_top = wdc_pkg::PRE_TOP_1;
			2'h1: presc_top = wdc_pkg::PRE_TOP_16;
			2'h2: presc_top = wdc_pkg::PRE_TOP_256;
			default: presc_top = wdc_pkg::PRE_TOP_4096;
		endcase
	end

	// Counting stops in shutdown, and in hibernate if asked.
	assign run = ctrl_t_r.enable && !(hib_s && ctrl_t_r.hib_stop) && !shut_s;
	// The counter expires at its last step.
	assign count_to = tick && run && !kick_pend_r && (presc_r >= presc_top) && (count_r <= 16'h0001);
	assign timeout_ev = count_to || kick_bad;
	// Interrupt timeout needs both the select bit and active mode.
	assign irq_mode = ctrl_t_r.irq_sel && act_s;

	// Prescaler and down counter.
	always_ff @(posedge clock or negedge rst_ni) begin
		if (!rst_ni) begin
			count_r <= wdc_pkg::LOAD_RST;
			presc_r <= 12'h000;
		end else if (tick) begin
			if (!ctrl_t_r.enable) begin
				// Disabled: the count is held at the load value.
				count_r <= load_t_r;
				presc_r <= 12'h000;
			end else if (kick_pend_r) begin
				// Service: start a fresh period.
				count_r <= load_t_r;
				presc_r <= 12'h000;
			end else if (run) begin
				// At or above the top, so a smaller divide never has to wrap first.
				if (presc_r >= presc_top) begin
					presc_r <= 12'h000;
					if (count_r <= 16'h0001) begin
						// Expiry: reloads and runs again, whatever the periodic bit holds.
						count_r <= load_t_r;
					end else begin
						count_r <= count_r - 16'h0001;
					end
				end else begin
					presc_r <= presc_r + 12'h001;
				end
			end
		end
	end

	// Timeout pending flag; a new timeout wins over a clearing kick.
	always_ff @(posedge clock or negedge rst_ni) begin
		if (!rst_ni) begin
			pend_r <= 1'b0;
		end else if (timeout_ev) begin
			pend_r <= 1'b1;
		end else if (tick && kick_pend_r) begin
			pend_r <= 1'b0;
		end
	end

	// Interrupt output level, only for interrupt mode timeouts.
	always_ff @(posedge clock or negedge rst_ni) begin
		if (!rst_ni) begin
			irq_r <= 1'b0;
		end else if (timeout_ev && irq_mode) begin
			irq_r <= 1'b1;
		end else if (tick && kick_pend_r) begin
			irq_r <= 1'b0;
		end
	end

	// Device reset request, one cycle per timeout in reset mode.
	always_ff @(posedge clock or negedge rst_ni) begin
		if (!rst_ni) begin
			reset_req_r <= 1'b0;
		end else begin
			reset_req_r <= timeout_ev && !irq_mode;
		end
	end

	// Read data stand only in the cycle after the read strobe.
	always_ff @(posedge clock or negedge rst_ni) begin
		if (!rst_ni) begin
			rdata_r <= 16'h0000;
		end else if (bus_req.rd) begin
			case (bus_req.addr)
				wdc_pkg::OFS_LOAD: rdata_r <= load_r;
				wdc_pkg::OFS_COUNT: rdata_r <= count_r;
				wdc_pkg::OFS_CTRL: rdata_r <= ctrl_r;
				// Status is built from live flags over the reserved pattern.
				wdc_pkg::OFS_FLAGS: rdata_r <= wdc_pkg::FLAGS_RSV | {11'h000, lock_r, ctrl_pend_r,
					load_pend_r, kick_pend_r, pend_r};
				// Write-only and unmapped addresses read zero.
				default: rdata_r <= 16'h0000;
			endcase
		end else begin
			rdata_r <= 16'h0000;
		end
	end

	assign rdata = rdata_r;
	assign wdog_reset_req = reset_req_r;
	assign wdog_irq = irq_r;

	// Checks on the design's own behaviour.
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_ni);

	lock_sticky_a: assert property (lock_r |=> lock_r)
		else $error("lock flag fell without reset");
	lock_set_a: assert property (wr_ctrl && bus_req.wdata[5] |=> lock_r)
		else $error("enabling write did not lock");
	lock_hold_a: assert property (lock_r && bus_req.wr |=> $stable(ctrl_r) && $stable(load_r))
		else $error("locked configuration changed");
	ctrl_sync_a: assert property (wr_ctrl || (ctrl_pend_r && !tick) |=> ctrl_pend_r)
		else $error("control pending dropped early");
	ctrl_apply_a: assert property (ctrl_pend_r && tick && !wr_ctrl
		|=> !ctrl_pend_r && ctrl_t_r == $past(ctrl_r))
		else $error("control change not applied");
	load_sync_a: assert property (load_pend_r && tick && !wr_load
		|=> !load_pend_r && load_t_r == $past(load_r))
		else $error("load change not applied");
	kick_pend_a: assert property (kick_good |=> kick_pend_r)
		else $error("kick pending not raised");
	kick_reload_a: assert property (kick_pend_r && tick && ctrl_t_r.enable && !kick_good
		|=> count_r == $past(load_t_r) && !kick_pend_r)
		else $error("kick did not reload");
	bad_kick_a: assert property (kick_bad |=> pend_r && (wdog_reset_req || wdog_irq))
		else $error("bad kick gave no timeout");
	reset_mode_a: assert property (timeout_ev && !irq_mode |=> wdog_reset_req ##1 (!wdog_reset_req || $past(timeout_ev)))
		else $error("reset request wrong");
	irq_mode_a: assert property (timeout_ev && irq_mode |=> wdog_irq && !wdog_reset_req)
		else $error("interrupt timeout wrong");
	disable_a: assert property (tick && !ctrl_t_r.enable |=> count_r == $past(load_t_r))
		else $error("disabled count not reset");
	hib_stop_a: assert property (tick && hib_s && ctrl_t_r.hib_stop && ctrl_t_r.enable && !kick_pend_r
		|=> $stable(count_r))
		else $error("count moved in hibernate");
	flags_rsv_a: assert property (bus_req.rd && bus_req.addr == wdc_pkg::OFS_FLAGS
		|=> rdata[15:5] == wdc_pkg::FLAGS_RSV[15:5])
		else $error("reserved flag bits wrong");

	kick_cov_c: cover property (kick_good ##[1:300] (tick && kick_pend_r));
	irq_cov_c: cover property (count_to && irq_mode);
	reset_cov_c: cover property (kick_bad && !irq_mode);
	lock_cov_c: cover property ($rose(lock_r));

endmodule

`default_nettype wire

/* File: wdc_pkg.sv */
// Shared constants and carriers of the watchdog control block.
package wdc_pkg;

	// Register byte addresses.
	localparam logic [31:0] OFS_LOAD = 32'h40002580;
	localparam logic [31:0] OFS_COUNT = 32'h40002584;
	localparam logic [31:0] OFS_CTRL = 32'h40002588;
	localparam logic [31:0] OFS_KICK = 32'h4000258c;
	localparam logic [31:0] OFS_FLAGS = 32'h40002598;

	// Reset values and the kick key.
	localparam logic [15:0] CTRL_RST = 16'h00e9;
	localparam logic [15:0] LOAD_RST = 16'h1000;
	localparam logic [15:0] FLAGS_RSV = 16'h0020;
	localparam logic [15:0] KICK_KEY = 16'hcccc;

	// Bit positions in the flags register.
	localparam int unsigned FLG_LOCK = 4;
	localparam int unsigned FLG_CTRL = 3;
	localparam int unsigned FLG_LOAD = 2;
	localparam int unsigned FLG_KICK = 1;
	localparam int unsigned FLG_PEND = 0;

	// Prescaler width and terminal counts per divide setting.
	localparam int unsigned PRE_W = 12;
	localparam logic [11:0] PRE_TOP_1 = 12'h000;
	localparam logic [11:0] PRE_TOP_16 = 12'h00f;
	localparam logic [11:0] PRE_TOP_256 = 12'h0ff;
	localparam logic [11:0] PRE_TOP_4096 = 12'hfff;

	// Pin indices of the synchronised inputs.
	localparam int unsigned PIN_OSC = 0;
	localparam int unsigned PIN_HIB = 1;
	localparam int unsigned PIN_SHUT = 2;
	localparam int unsigned PIN_ACT = 3;
	localparam int unsigned PIN_N = 4;

	// Control register layout.
	typedef struct packed {
		logic [8:0] rsv_hi;
		logic periodic;
		logic enable;
		logic rsv4;
		logic [1:0] pre;
		logic irq_sel;
		logic hib_stop;
	} wdc_ctrl_t;

	// One register bus request.
	typedef struct packed {
		logic [31:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} wdc_bus_req_t;

endpackage

/* File: wdc_testbench.sv */
`timescale 1ns/10ps
`default_nettype none

// Counts one comparison and reports it at once when the values differ.
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; $display("MISMATCH at %0t: got %h expected %h", $time, g, e); end end

module testbench;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	wdc_pkg::wdc_bus_req_t req = '0;
	logic [15:0] rdata;
	logic osc_in = 1'b0;
	logic hibernate_in = 1'b0;
	logic shutdown_in = 1'b0;
	logic active_in = 1'b0;
	logic wdog_reset_req;
	logic wdog_irq;
	// Test control and bookkeeping.
	logic osc_run = 1'b1;
	int rst_cnt = 0;
	int rst_mark = 0;
	logic [31:0] seed = 32'h2d3e2ebf;
	logic [15:0] v, a, load_v;
	int err_count = 0;
	int total_checks = 0;
	int cyc = 0;

	// The core clock runs at 40 MHz.
	always #12.5 clock = ~clock;

	// Counts cycles, toggles the slow oscillator every four clocks while allowed,
	// counts reset requests and cuts a hang short.
	always @(posedge clock) begin
		cyc++;
		if (osc_run && cyc % 4 == 0) osc_in <= ~osc_in;
		if (wdog_reset_req === 1'b1) rst_cnt++;
		if (cyc > 20000) begin
			err_count++;
			conclude();
		end
	end

	wdc_watchdog wdc_watchdog_i (
		.clock(clock),
		.rst_n(rst_n),
		.bus_req(req),
		.rdata(rdata),
		.osc_in(osc_in),
		.hibernate_in(hibernate_in),
		.shutdown_in(shutdown_in),
		.active_in(active_in),
		.wdog_reset_req(wdog_reset_req),
		.wdog_irq(wdog_irq)
	);

	// Next value of the repeatable random sequence.
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	// One write cycle on the register port.
	task automatic wr(input logic [31:0] ad, input logic [15:0] d);
		@(posedge clock);
		req.addr <= ad;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clock);
		req.wr <= 1'b0;
	endtask

	// One read cycle; data are taken in the cycle after the strobe.
	task automatic rd(input logic [31:0] ad, output logic [15:0] d);
		@(posedge clock);
		req.addr <= ad;
		req.rd <= 1'b1;
		@(posedge clock);
		req.rd <= 1'b0;
		#1 d = rdata;
	endtask

	// Reads the flags until they match, with a bounded number of tries.
	task automatic poll(input logic [15:0] e);
		int n;
		n = 0;
		rd(wdc_pkg::OFS_FLAGS, v);
		while (v !== e && n < 80) begin
			rd(wdc_pkg::OFS_FLAGS, v);
			n++;
		end
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		// Reset values, a write-only read and an unmapped read.
		rd(wdc_pkg::OFS_CTRL, v); `CHK(v, 16'h00e9)
		`CHK(v[6], 1'b1)
		`CHK(v[5], 1'b1)
		rd(wdc_pkg::OFS_LOAD, v); `CHK(v, 16'h1000)
		rd(wdc_pkg::OFS_COUNT, v); `CHK(v, 16'h1000)
		rd(wdc_pkg::OFS_KICK, v); `CHK(v, 16'h0000)
		rd(32'h40002590, v); `CHK(v, 16'h0000)
		wr(wdc_pkg::OFS_FLAGS, 16'hffff);
		rd(wdc_pkg::OFS_FLAGS, v); `CHK(v, 16'h0020)
		$display("reset values done");
		// With the reset control the count stops in hibernate for over one divide period.
		hibernate_in <= 1'b1;
		repeat (6) @(posedge clock);
		rd(wdc_pkg::OFS_COUNT, a);
		repeat (2100) @(posedge clock);
		rd(wdc_pkg::OFS_COUNT, v); `CHK(v, a)
		hibernate_in <= 1'b0;
		$display("hibernate stop done");
		// A wrong key times out at once in reset mode.
		osc_run <= 1'b0;
		seed = xs(seed);
		v = seed[15:0] ^ 16'h0001;
		if (v == 16'hcccc) v = 16'h0000;
		wr(wdc_pkg::OFS_KICK, v);
		#1 `CHK(wdog_reset_req, 1'b1)
		`CHK(wdog_irq, 1'b0)
		@(posedge clock);
		#1 `CHK(wdog_reset_req, 1'b0)
		rd(wdc_pkg::OFS_FLAGS, v); `CHK(v, 16'h0021)
		// The key raises kick pending until the timer side takes it.
		wr(wdc_pkg::OFS_KICK, 16'hcccc);
		rd(wdc_pkg::OFS_FLAGS, v); `CHK(v, 16'h0023)
		osc_run <= 1'b1;
		poll(16'h0020); `CHK(v, 16'h0020)
		$display("kick done");
		// Disable, new load value and their pending flags.
		osc_run <= 1'b0;
		wr(wdc_pkg::OFS_CTRL, 16'h0040);
		rd(wdc_pkg::OFS_FLAGS, v); `CHK(v, 16'h0028)
		seed = xs(seed);
		load_v = seed[15:0] | 16'h0100;
		wr(wdc_pkg::OFS_LOAD, load_v);
		rd(wdc_pkg::OFS_FLAGS, v); `CHK(v, 16'h002c)
		osc_run <= 1'b1;
		poll(16'h0020); `CHK(v, 16'h0020)
		repeat (20) @(posedge clock);
		rd(wdc_pkg::OFS_COUNT, v); `CHK(v, load_v)
		$display("disable done");
		// Enable with interrupt timeout, divide by one and a short load.
		active_in <= 1'b1;
		wr(wdc_pkg::OFS_LOAD, 16'h0006);
		poll(16'h0020);
		rst_mark = rst_cnt;
		wr(wdc_pkg::OFS_CTRL, 16'h0062);
		rd(wdc_pkg::OFS_FLAGS, v); `CHK(v[4], 1'b1)
		for (int n = 0; n < 300 && wdog_irq !== 1'b1; n++) @(posedge clock);
		`CHK(wdog_irq, 1'b1)
		`CHK(rst_cnt, rst_mark)
		rd(wdc_pkg::OFS_FLAGS, v); `CHK(v[4:0], 5'h11)
		// Further configuration is ignored once locked.
		wr(wdc_pkg::OFS_CTRL, 16'h0000);
		rd(wdc_pkg::OFS_CTRL, v); `CHK(v, 16'h0062)
		wr(wdc_pkg::OFS_LOAD, 16'h0100);
		rd(wdc_pkg::OFS_LOAD, v); `CHK(v, 16'h0006)
		wr(wdc_pkg::OFS_KICK, 16'hcccc);
		for (int n = 0; n < 100 && wdog_irq !== 1'b0; n++) @(posedge clock);
		`CHK(wdog_irq, 1'b0)
		$display("lock done");
		// Outside active mode a wrong key requests a reset.
		active_in <= 1'b0;
		repeat (5) @(posedge clock);
		wr(wdc_pkg::OFS_KICK, 16'h1234);
		#1 `CHK(wdog_reset_req, 1'b1)
		// Shutdown freezes the count; hibernate does not when stop is off.
		shutdown_in <= 1'b1;
		repeat (6) @(posedge clock);
		rd(wdc_pkg::OFS_COUNT, a);
		repeat (40) @(posedge clock);
		rd(wdc_pkg::OFS_COUNT, v); `CHK(v, a)
		shutdown_in <= 1'b0;
		hibernate_in <= 1'b1;
		repeat (6) @(posedge clock);
		rd(wdc_pkg::OFS_COUNT, a);
		repeat (12) @(posedge clock);
		rd(wdc_pkg::OFS_COUNT, v); `CHK(v !== a, 1'b1)
		$display("power modes done");
		conclude();
	end
endmodule

`default_nettype wire
